//--- hdl/dsf_pkg.sv
// package of constants and types for the dual synchronous 9-bit fifo
// assumes: included before every other file of the block
//
// Operation
// (R1) Two independent channels with identical behaviour and their own signals.
// (R2) Each channel writes and reads nine-bit words.
// (R3) Channel reset low returns read and write pointers to location zero.
// (R4) Reset drives full and almost-full high, empty and almost-empty low.
// (R5) Reset zeroes the output register and restores offset defaults.
// (R6) Outside logic resets each channel after power-up before writing.
// (R7) Writes start on write clock rising edges; full flags follow that clock.
// (R8) Works with unrelated or identical read and write clocks.
// (R9) Load pin sampled during reset: high two-enable mode, low flag mode.
// (R10) Flag mode: store a word each write edge while enable one low.
// (R11) Two-enable mode: store only with enable one low and enable two high.
// (R12) Words go to sequential locations independent of reads.
// (R13) Full flag low ignores writes; a read releases it.
// (R14) Output register loads next word only when both read enables low.
// (R15) Empty flag low ignores reads; a write releases it.
// (R16) Empty and almost-empty flags follow the read clock.
// (R17) Output enable low drives data; high floats the outputs.
// (R18) Flag mode offers four eight-bit offset registers, written and read.
// (R19) Load-low writes rotate empty low, empty high, full low, full high.
// (R20) Raising load resumes fifo use and keeps rotation position.
// (R21) Load low with read enables low reads offsets in same rotation.
// (R22) Outside logic avoids reading and writing offsets together.
// (R23) Almost-full low when count reaches depth minus full offset.
// (R24) Almost-empty low while count at or below empty offset.
// (R25) Depth is a parameter; pointers cross domains gray-coded and synchronised.
package dsf_pkg;
    localparam int DATA_W = 9;
    localparam int OFS_W = 8;
    localparam int DEPTH_LOG2 = 8;
    localparam logic [15:0] EMPTY_OFS_RST = 16'h0007;
    localparam logic [15:0] FULL_OFS_RST = 16'h0007;
    // rotation index of the offset registers
    localparam logic [1:0] SEL_EMPTY_LO = 2'h0;
    localparam logic [1:0] SEL_EMPTY_HI = 2'h1;
    localparam logic [1:0] SEL_FULL_LO = 2'h2;
    localparam logic [1:0] SEL_FULL_HI = 2'h3;

    // write-side pins of one channel
    typedef struct packed {
        logic [DATA_W-1:0] writeDataIn;
        logic writeEnableOneN;
        logic writeEnableTwoOrLoadN;
    } dsf_wr_t;

    // read-side pins of one channel
    typedef struct packed {
        logic readEnableOneN;
        logic readEnableTwoN;
        logic outputEnableN;
    } dsf_rd_t;

    // outputs of one channel
    typedef struct packed {
        logic [DATA_W-1:0] readDataOut;
        logic readDataOe;
        logic fullFlagN;
        logic almostFullFlagN;
        logic emptyFlagN;
        logic almostEmptyFlagN;
    } dsf_out_t;
endpackage

//--- hdl/dsf_sync.sv
// two-flop synchroniser for a vector of gray-coded bits
// assumes: each bit changes alone per source edge (gray pointer)
`timescale 1ns/1ps
module dsf_sync #(
    parameter int W = 9
) (
    // destination clock
    input wire logic clk,
    input wire logic resetN,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

//--- hdl/dsf_fifo.sv
// one fifo channel and the two-channel top of the dual 9-bit fifo
// assumes: each channel's clocks and reset come from pins; clocks may be unrelated
`timescale 1ns/1ps
module dsf_channel #(
    parameter int DEPTH_LOG2 = dsf_pkg::DEPTH_LOG2
) (
    // clocks and channel reset
    input wire logic writeClock,
    input wire logic readClock,
    input wire logic resetN,
    // pins
    input wire dsf_pkg::dsf_wr_t wr,
    input wire dsf_pkg::dsf_rd_t rd,
    output dsf_pkg::dsf_out_t out
);
    localparam int AW = DEPTH_LOG2;
    localparam int PW = DEPTH_LOG2 + 1;
    localparam logic [PW-1:0] DEPTH = PW'(1 << DEPTH_LOG2);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        // top bit passes straight; each lower bit folds in the one above it
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction

    // write-domain state
    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] wrGray;
        logic flagMode;
        logic modeSeen;
        logic [1:0] wrSel;
        logic [15:0] emptyOfs;
        logic [15:0] fullOfs;
        logic fullN;
        logic almostFullN;
    } dsf_wst_t;

    // read-domain state
    typedef struct packed {
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] rdGray;
        logic [1:0] rdSel;
        logic [dsf_pkg::DATA_W-1:0] dataOut;
        logic emptyN;
        logic almostEmptyN;
    } dsf_rst_t;

    dsf_wst_t w_r, w_nxt;
    dsf_rst_t r_r, r_nxt;
    logic [dsf_pkg::DATA_W-1:0] mem [0:(1<<AW)-1];
    logic [PW-1:0] rdGraySync, wrGraySync;
    logic modeSampleN_r;
    logic [1:0] rdMeta_r;
    logic [1:0] ldSync_r;
    logic wrDo, rdDo, ofsWr, ofsRd;
    logic [PW-1:0] wrCount, rdCount, rdBin, wrBin;

    // pointers cross domains as gray code through two flops [R25] [R8]
    dsf_sync #(.W(PW)) u_syncRd (.clk(writeClock), .resetN(resetN), .d(r_r.rdGray), .q(rdGraySync));
    dsf_sync #(.W(PW)) u_syncWr (.clk(readClock), .resetN(resetN), .d(w_r.wrGray), .q(wrGraySync));

    // load pin level seen in read domain, through two flops
    always_ff @(posedge readClock or negedge resetN) begin
        if (!resetN) begin
            ldSync_r <= 2'h3;
        end else begin
            ldSync_r <= {ldSync_r[0], wr.writeEnableTwoOrLoadN};
        end
    end

    // mode strap: the last level seen while reset is held is kept [R9]
    always_ff @(posedge writeClock) begin
        if (!resetN) begin
            modeSampleN_r <= wr.writeEnableTwoOrLoadN;
        end
    end

    // write decode; full flag blocks stores [R10] [R11] [R13]
    always_comb begin
        ofsWr = w_r.flagMode && !wr.writeEnableTwoOrLoadN && !wr.writeEnableOneN;
        if (w_r.flagMode) begin
            wrDo = !wr.writeEnableOneN && wr.writeEnableTwoOrLoadN && w_r.fullN; // [R10]
        end else begin
            wrDo = !wr.writeEnableOneN && wr.writeEnableTwoOrLoadN && w_r.fullN; // [R11]
        end
        rdBin = gray2bin(rdGraySync);
    end

    // write-side next state
    always_comb begin
        w_nxt = w_r;
        if (!w_r.modeSeen) begin
            // first edge after release adopts the strap; mode picks offset path
            w_nxt.modeSeen = 1'b1;
            w_nxt.flagMode = !modeSampleN_r; // [R9]
        end
        if (wrDo) begin
            w_nxt.wrPtr = PW'(w_r.wrPtr + 1'b1); // sequential locations [R12]
        end
        if (ofsWr) begin
            // rotating offset load, position kept across load high [R19] [R20]
            unique case (w_r.wrSel)
                dsf_pkg::SEL_EMPTY_LO: w_nxt.emptyOfs[7:0] = wr.writeDataIn[7:0];
                dsf_pkg::SEL_EMPTY_HI: w_nxt.emptyOfs[15:8] = wr.writeDataIn[7:0];
                dsf_pkg::SEL_FULL_LO: w_nxt.fullOfs[7:0] = wr.writeDataIn[7:0];
                dsf_pkg::SEL_FULL_HI: w_nxt.fullOfs[15:8] = wr.writeDataIn[7:0];
            endcase
            w_nxt.wrSel = 2'(w_r.wrSel + 1'b1); // [R18]
        end
        w_nxt.wrGray = bin2gray(w_nxt.wrPtr);
        wrCount = PW'(w_nxt.wrPtr - rdBin);
        // flags on write clock; full released once a read is seen [R7] [R13]
        w_nxt.fullN = (wrCount != DEPTH);
        w_nxt.almostFullN = ({{(16-PW){1'b0}}, wrCount} < ({{(16-PW){1'b0}}, DEPTH} - w_r.fullOfs)); // [R23]
    end

    // storage write port [R2]
    always_ff @(posedge writeClock) begin
        if (wrDo) begin
            mem[w_r.wrPtr[AW-1:0]] <= wr.writeDataIn;
        end
    end

    // write-domain register; reset holds pointers at zero [R3] [R4] [R5]
    always_ff @(posedge writeClock or negedge resetN) begin
        if (!resetN) begin
            w_r <= '{wrPtr: '0, wrGray: '0, flagMode: 1'b0, modeSeen: 1'b0, wrSel: dsf_pkg::SEL_EMPTY_LO,
                     emptyOfs: dsf_pkg::EMPTY_OFS_RST, fullOfs: dsf_pkg::FULL_OFS_RST,
                     fullN: 1'b1, almostFullN: 1'b1};
        end else begin
            w_r <= w_nxt;
        end
    end

    // read decode: empty blocks reads, offset reads when load low [R14] [R15] [R21]
    always_comb begin
        logic bothLow;
        bothLow = !rd.readEnableOneN && !rd.readEnableTwoN;
        ofsRd = w_r.flagMode && !ldSync_r[1] && bothLow;
        rdDo = bothLow && !ofsRd && r_r.emptyN;
        wrBin = gray2bin(wrGraySync);
    end

    // read-side next state
    always_comb begin
        r_nxt = r_r;
        if (rdDo) begin
            r_nxt.dataOut = mem[r_r.rdPtr[AW-1:0]]; // [R14]
            r_nxt.rdPtr = PW'(r_r.rdPtr + 1'b1);
        end else if (ofsRd) begin
            // offset read-back in the same rotation; bit 8 reads zero [R21]
            unique case (r_r.rdSel)
                dsf_pkg::SEL_EMPTY_LO: r_nxt.dataOut = {1'b0, w_r.emptyOfs[7:0]};
                dsf_pkg::SEL_EMPTY_HI: r_nxt.dataOut = {1'b0, w_r.emptyOfs[15:8]};
                dsf_pkg::SEL_FULL_LO: r_nxt.dataOut = {1'b0, w_r.fullOfs[7:0]};
                dsf_pkg::SEL_FULL_HI: r_nxt.dataOut = {1'b0, w_r.fullOfs[15:8]};
            endcase
            r_nxt.rdSel = 2'(r_r.rdSel + 1'b1);
        end
        r_nxt.rdGray = bin2gray(r_nxt.rdPtr);
        rdCount = PW'(wrBin - r_nxt.rdPtr);
        // flags on read clock [R16] [R15]
        r_nxt.emptyN = (rdCount != '0);
        r_nxt.almostEmptyN = ({{(16-PW){1'b0}}, rdCount} > w_r.emptyOfs); // [R24]
    end

    // read-domain register; offsets are static outside load so read here directly
    always_ff @(posedge readClock or negedge resetN) begin
        if (!resetN) begin
            r_r <= '{rdPtr: '0, rdGray: '0, rdSel: dsf_pkg::SEL_EMPTY_LO, dataOut: '0,
                     emptyN: 1'b0, almostEmptyN: 1'b0}; // [R3] [R4] [R5]
        end else begin
            r_r <= r_nxt;
        end
    end

    // pin outputs; three-state resolved outside [R17]
    always_comb begin
        out.readDataOut = r_r.dataOut;
        out.readDataOe = !rd.outputEnableN;
        out.fullFlagN = w_r.fullN;
        out.almostFullFlagN = w_r.almostFullN;
        out.emptyFlagN = r_r.emptyN;
        out.almostEmptyFlagN = r_r.almostEmptyN;
    end
endmodule

module dsf_dual_fifo #(
    parameter int DEPTH_LOG2 = dsf_pkg::DEPTH_LOG2
) (
    // per-channel clocks and active-low resets
    input wire logic [1:0] writeClock,
    input wire logic [1:0] readClock,
    input wire logic [1:0] resetN,
    // per-channel pins
    input wire dsf_pkg::dsf_wr_t [1:0] wr,
    input wire dsf_pkg::dsf_rd_t [1:0] rd,
    output dsf_pkg::dsf_out_t [1:0] out
);
    // two identical, independent channels [R1]
    for (genvar c = 0; c < 2; c++) begin : g_ch
        dsf_channel #(.DEPTH_LOG2(DEPTH_LOG2)) u_ch (
            .writeClock(writeClock[c]),
            .readClock(readClock[c]),
            .resetN(resetN[c]),
            .wr(wr[c]),
            .rd(rd[c]),
            .out(out[c])
        );
    end
endmodule

//--- dv/dsf_monitor.sv
// checker for channel zero of the dual fifo
// assumes: bound to dsf_dual_fifo; channel one is its twin
`timescale 1ns/1ps
module dsf_monitor #(
    parameter int DEPTH_LOG2 = 8
) (
    // clocks and resets
    input wire logic [1:0] writeClock,
    input wire logic [1:0] readClock,
    input wire logic [1:0] resetN,
    // pins
    input wire dsf_pkg::dsf_wr_t [1:0] wr,
    input wire dsf_pkg::dsf_rd_t [1:0] rd,
    input wire dsf_pkg::dsf_out_t [1:0] out
);
    // short names for channel zero
    wire wc = writeClock[0];
    wire rc = readClock[0];
    wire rn = resetN[0];
    wire ld = wr[0].writeEnableTwoOrLoadN;
    wire rdLow = !rd[0].readEnableOneN && !rd[0].readEnableTwoN;
    dsf_pkg::dsf_out_t o;
    assign o = out[0];

    // flags are checked in their own clock domain
    property p_rst_wr; @(posedge wc) disable iff (!rn) $rose(rn) |-> o.fullFlagN && o.almostFullFlagN; endproperty
    a_rst_wr: assert property (p_rst_wr) else $error("write flags after reset");
    property p_rst_rd; @(posedge rc) disable iff (!rn) $rose(rn) |-> !o.emptyFlagN && !o.almostEmptyFlagN
        && o.readDataOut == 9'h000; endproperty
    a_rst_rd: assert property (p_rst_rd) else $error("read side after reset");
    property p_hold; @(posedge rc) disable iff (!rn) !rdLow |=> $stable(o.readDataOut); endproperty
    a_hold: assert property (p_hold) else $error("output moved without read");
    // load must have stood high a while, since offset reads follow it late
    property p_empty; @(posedge rc) disable iff (!rn) ld [*3] ##0 !o.emptyFlagN |=> $stable(o.readDataOut); endproperty
    a_empty: assert property (p_empty) else $error("read taken while empty");
    property p_oe; @(posedge rc) disable iff (!rn) o.readDataOe == !rd[0].outputEnableN; endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_af; @(posedge wc) disable iff (!rn) !o.fullFlagN |-> !o.almostFullFlagN; endproperty
    a_af: assert property (p_af) else $error("full without almost full");
    property p_full; @(posedge wc) disable iff (!rn) $fell(o.fullFlagN) |-> !$past(wr[0].writeEnableOneN); endproperty
    a_full: assert property (p_full) else $error("full with no write");
    property p_efall; @(posedge rc) disable iff (!rn) $fell(o.emptyFlagN) |-> $past(rdLow); endproperty
    a_efall: assert property (p_efall) else $error("empty with no read");
    // main scenarios
    c_full: cover property (@(posedge wc) $fell(o.fullFlagN));
    c_empty: cover property (@(posedge rc) $rose(o.emptyFlagN));
    c_af: cover property (@(posedge wc) $fell(o.almostFullFlagN));
endmodule

bind dsf_dual_fifo dsf_monitor #(.DEPTH_LOG2(DEPTH_LOG2)) i_mon (.writeClock(writeClock), .readClock(readClock),
    .resetN(resetN), .wr(wr), .rd(rd), .out(out));

//--- dv/dsf_peer.sv
// reader on a channel's read port
// assumes: go and slow change just after the read clock edge
`timescale 1ns/1ps
module dsf_peer (
    // read clock
    input wire logic clk,
    // bench requests
    input wire logic go,
    input wire logic slow,
    input wire logic oeN,
    // read pins
    output dsf_pkg::dsf_rd_t rd
);
    logic tick_r = 1'b0;
    initial rd = '1;
    // slow mode drops enable one every other edge, as a busy reader does
    always @(posedge clk) begin
        tick_r <= !tick_r;
        rd.readEnableOneN <= !(go && (!slow || tick_r));
        rd.readEnableTwoN <= !go;
        rd.outputEnableN <= oeN;
    end
endmodule

//--- dv/dsf_dual_fifo_tb.sv
// self-checking bench for the dual 9-bit fifo
// assumes: one 100 MHz clock feeds every port; depth cut to 16
`timescale 1ns/1ps
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module dsf_dual_fifo_tb;
    logic clk = 1'b0;
    logic [1:0] rstN;
    logic go, slow, oeN;
    dsf_pkg::dsf_wr_t w0, w1;
    dsf_pkg::dsf_rd_t rd0;
    dsf_pkg::dsf_out_t [1:0] out;
    int failures = 0;
    int num_checks = 0;
    logic [8:0] expQ[$];

    always #5 clk = !clk;
    // channel one sees channel zero's data and enable two but never write enable one
    assign w1 = '{w0.writeDataIn, 1'b1, w0.writeEnableTwoOrLoadN};
    dsf_dual_fifo #(.DEPTH_LOG2(4)) i_dut (.writeClock({2{clk}}), .readClock({2{clk}}), .resetN(rstN),
        .wr({w1, w0}), .rd({rd0, rd0}), .out(out));
    dsf_peer i_peer (.clk(clk), .go(go), .slow(slow), .oeN(oeN), .rd(rd0));

    // every change of channel zero's output must be the next queued word
    always @(out[0].readDataOut) if (rstN[0] === 1'b1) begin
        `CK("data", expQ.size() ? expQ[0] : 9'h1FF, out[0].readDataOut)
        if (expQ.size() > 0) void'(expQ.pop_front());
    end

    task automatic close_out;
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // cross-domain flags need two sync edges plus one
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask

    task automatic rst(input logic ld);
        rstN <= 2'b00;
        w0 <= '{9'h000, 1'b1, ld};
        repeat (6) @(posedge clk);
        `CK("rst flags", 4'hC, {out[0].fullFlagN, out[0].almostFullFlagN, out[0].emptyFlagN, out[0].almostEmptyFlagN})
        `CK("rst data", 9'h000, out[0].readDataOut)
        rstN <= 2'b11;
        expQ.delete();
        settle();
    endtask

    task automatic put(input int n, input logic [8:0] base);
        for (int i = 0; i < n; i++) begin
            w0 <= '{base + 9'(i), 1'b0, 1'b1};
            expQ.push_back(base + 9'(i));
            @(posedge clk);
        end
        w0.writeEnableOneN <= 1'b1;
        settle();
    endtask

    task automatic get(input logic s);
        go <= 1'b1;
        slow <= s;
        for (int i = 0; i < 200 && expQ.size() > 0; i++) @(posedge clk);
        go <= 1'b0;
        settle();
        `CK("drained", 0, expQ.size())
        `CK("empty", 2'b00, {out[0].emptyFlagN, out[0].almostEmptyFlagN})
    endtask

    // two-enable mode: refusal, default thresholds, overflow, stalled drain
    task automatic two_enable;
        rst(1'b1);
        w0 <= '{9'h0AA, 1'b0, 1'b0};
        settle();
        `CK("refused", 1'b0, out[0].emptyFlagN)
        put(8, 9'h100);
        `CK("8 words", 2'b11, {out[0].almostFullFlagN, out[0].almostEmptyFlagN})
        put(1, 9'h108);
        `CK("9 words", 1'b0, out[0].almostFullFlagN)
        put(8, 9'h109);
        void'(expQ.pop_back());
        `CK("full", 3'b000, {out[0].fullFlagN, out[0].almostFullFlagN, out[1].emptyFlagN})
        `CK("ch1 idle", 12'hC00, {out[1].fullFlagN, out[1].almostFullFlagN, out[1].almostEmptyFlagN, out[1].readDataOut})
        oeN <= 1'b1;
        settle();
        `CK("oe", 1'b0, out[0].readDataOe)
        oeN <= 1'b0;
        get(1'b1);
        `CK("full gone", 1'b1, out[0].fullFlagN)
    endtask

    // flag mode: offset rotation, read-back, programmed thresholds
    task automatic flag_mode;
        rst(1'b0);
        w0 <= '{9'h003, 1'b0, 1'b0};
        @(posedge clk);
        w0 <= '{9'h000, 1'b0, 1'b0};
        @(posedge clk);
        w0 <= '{9'h000, 1'b1, 1'b1};
        @(posedge clk);
        w0 <= '{9'h004, 1'b0, 1'b0};
        @(posedge clk);
        w0 <= '{9'h000, 1'b1, 1'b0};
        settle();
        expQ = '{9'h003, 9'h000, 9'h004, 9'h000};
        // full-rate reader, so all four offsets come back inside the window
        slow <= 1'b0;
        go <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b0;
        settle();
        `CK("offsets", 0, expQ.size())
        w0.writeEnableTwoOrLoadN <= 1'b1;
        settle();
        put(3, 9'h020);
        `CK("3 words", 1'b0, out[0].almostEmptyFlagN)
        put(1, 9'h023);
        `CK("4 words", 1'b1, out[0].almostEmptyFlagN)
        put(7, 9'h024);
        `CK("11 words", 1'b1, out[0].almostFullFlagN)
        put(1, 9'h02B);
        `CK("12 words", 1'b0, out[0].almostFullFlagN)
        get(1'b0);
    endtask

    initial begin
        rstN = 2'b00;
        w0 = '{9'h000, 1'b1, 1'b1};
        {go, slow, oeN} = 3'b000;
        two_enable();
        flag_mode();
        close_out();
    end

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        failures++;
        close_out();
    end
endmodule
